// ---- atrb_chk_asserts.sv ----
// Checker for the trim register bank ports
`timescale 1ns/1ps
module atrb_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] overcurrent_delay_sel,
	input wire logic [15:0] overcurrent_filter_cycles,
	input wire logic signed [4:0] ref_adjust_pct
);
	// =====
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_IDLE: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not cleared");
	AST_RDLO: assert property (reg_rdata[5:0] == 6'h00)
		else $error("write-only bits readable");
	AST_RDWO: assert property (clk_en && reg_rd && reg_addr != 8'h0F |=>
		reg_rdata == 8'h00) else $error("write-only register readable");
	AST_FILT: assert property (overcurrent_filter_cycles ==
		(overcurrent_delay_sel[1] ?
		(overcurrent_delay_sel[0] ? 16'h079E : 16'h16DA) :
		(overcurrent_delay_sel[0] ? 16'h3458 : 16'h5CC6)))
		else $error("filter count wrong");
	AST_WR: assert property (clk_en && reg_wr && reg_addr == 8'h0F ##1
		clk_en && !reg_wr |=> overcurrent_delay_sel == $past(reg_wdata, 2) >> 6)
		else $error("delay field not written");
	// A write elsewhere must not disturb the delay field
	AST_STAB: assert property (clk_en && reg_wr && reg_addr != 8'h0F ##1
		!reg_wr |=> $stable(overcurrent_delay_sel)) else $error("delay disturbed");
	AST_RST: assert property ($rose(reset_n) |-> overcurrent_delay_sel == 2'h0
		&& ref_adjust_pct == 5'sd0) else $error("reset values wrong");
	AST_REF: assert property (ref_adjust_pct >= -5'sd12 &&
		ref_adjust_pct <= 5'sd12) else $error("reference trim out of range");
	cover property (reg_wr && reg_addr == 8'h0F);
	cover property (reg_rd && reg_addr == 8'h0F);
	cover property (overcurrent_delay_sel == 2'h3);
endmodule
bind atrb_top atrb_chk u_chk (.*);

// ---- atrb_mcu.sv ----
// Host controller model that loads the trim bank
`timescale 1ns/1ps
module atrb_mcu (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// =====
	// Bus access
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(negedge clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(negedge clk);
		// Released lines show the inverse so stale data is never trusted
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
	endtask
	// ordered copy, test offset unused, spare bits clear
	task automatic boot(input logic [7:0] b1, b2, b3);
		acc(1'b1, 8'h0F, b1 & 8'hCF);
		acc(1'b1, 8'h10, b2);
		acc(1'b1, 8'h11, b3);
	endtask
endmodule

// ---- atrb_pkg.sv ----
// Package with constants for the analog trim register bank
// Behaviour
// - The two-bit over-current delay field is read/write and resets to the longest delay.
// - Delay codes 00,01,10,11 give about 950, 536, 234 and 78 us of filter time.
// - The four-bit current reference trim field is write-only and resets to zero.
// - Reference trim codes give 0, +2, +4, +8, +12, -2, -4, -8, -12 percent.
// - The second and third trim registers are write-only, read as zero and reset to zero.
// - With sense select 0, second register bits 7:6 trim bridge 1-2 recopy gain.
// - With sense select 1, second register bits 5:3 trim bridge 3-4 recopy gain.
// - With sense select 1, second register bits 2:0 trim bridge 1-2 recopy gain.
// - Three-bit recopy codes give 0, -5, -10, -15, reserved, +5, +10, +15 percent.
// - With sense select 0, third register bits 7:6 trim bridge 3-4 recopy gain.
// - Third register bits 5:3 trim high-side 2-3 recopy gain.
// - Third register bits 2:0 trim high-side 1 recopy gain.
package atrb_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] TEST_OFS   = 8'h0E;
	localparam logic [7:0] TRIM1_OFS  = 8'h0F;
	localparam logic [7:0] TRIM2_OFS  = 8'h10;
	localparam logic [7:0] TRIM3_OFS  = 8'h11;
	localparam logic [7:0] TRIM_RESET = 8'h00;
	// ==========================================
	// Field positions
	localparam int DLY_LSB  = 6;
	localparam int REF_LSB  = 0;
	localparam int HI2_LSB  = 6;
	localparam int MID3_LSB = 3;
	localparam int LO3_LSB  = 0;
	localparam logic [7:0] TRIM1_RD_MASK = 8'hC0;
	// ==========================================
	// Filter delays in ns and cycles at 25 MHz
	localparam int CLK_NS   = 40;
	localparam int DLY0_NS  = 950000;
	localparam int DLY1_NS  = 536000;
	localparam int DLY2_NS  = 234000;
	localparam int DLY3_NS  = 78000;
	localparam int DLY0_CYC = DLY0_NS / CLK_NS;
	localparam int DLY1_CYC = DLY1_NS / CLK_NS;
	localparam int DLY2_CYC = DLY2_NS / CLK_NS;
	localparam int DLY3_CYC = DLY3_NS / CLK_NS;
endpackage

// ---- atrb_top.sv ----
// Analog trim register bank with decoded trim outputs
`timescale 1ns/1ps
module atrb_top (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              clk_en,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              current_sense_select,
	output logic      [7:0]        reg_rdata,
	output logic      [1:0]        overcurrent_delay_sel,
	output logic      [15:0]       overcurrent_filter_cycles,
	output logic signed [4:0]      ref_adjust_pct,
	output logic signed [4:0]      bridge12_adjust_pct,
	output logic signed [4:0]      bridge34_adjust_pct,
	output logic signed [4:0]      highside23_adjust_pct,
	output logic signed [4:0]      highside1_adjust_pct
);
	// ==========================================
	// Decode functions
	function automatic logic signed [4:0] ref_pct(input logic [3:0] c);
		case (c)
			4'h1: ref_pct = 5'sd2;
			4'h2: ref_pct = 5'sd4;
			4'h3: ref_pct = 5'sd8;
			4'h4: ref_pct = 5'sd12;
			4'h5: ref_pct = -5'sd2;
			4'h6: ref_pct = -5'sd4;
			4'h7: ref_pct = -5'sd8;
			4'h8: ref_pct = -5'sd12;
			default: ref_pct = 5'sd0;
		endcase
	endfunction

	function automatic logic signed [4:0] pct3(input logic [2:0] c);
		case (c)
			3'h1: pct3 = -5'sd5;
			3'h2: pct3 = -5'sd10;
			3'h3: pct3 = -5'sd15;
			3'h5: pct3 = 5'sd5;
			3'h6: pct3 = 5'sd10;
			3'h7: pct3 = 5'sd15;
			// Reserved 100 gives no adjustment, as does 000
			default: pct3 = 5'sd0;
		endcase
	endfunction

	function automatic logic signed [4:0] pct2(input logic [1:0] c);
		case (c)
			2'h1: pct2 = -5'sd10;
			2'h2: pct2 = 5'sd5;
			2'h3: pct2 = 5'sd10;
			default: pct2 = 5'sd0;
		endcase
	endfunction

	function automatic logic [15:0] dly_cyc(input logic [1:0] c);
		case (c)
			2'h1: dly_cyc = 16'(atrb_pkg::DLY1_CYC);
			2'h2: dly_cyc = 16'(atrb_pkg::DLY2_CYC);
			2'h3: dly_cyc = 16'(atrb_pkg::DLY3_CYC);
			default: dly_cyc = 16'(atrb_pkg::DLY0_CYC);
		endcase
	endfunction

	// ==========================================
	// Register state
	logic [7:0] trim1_q, trim1_d;
	logic [7:0] trim2_q, trim2_d;
	logic [7:0] trim3_q, trim3_d;
	logic [7:0] rdata_d;
	logic       sel_s1_q, sel_s2_q;

	always_comb begin
		trim1_d = trim1_q;
		trim2_d = trim2_q;
		trim3_d = trim3_q;
		rdata_d = 8'h00;
		if (reg_wr) begin
			case (reg_addr)
				atrb_pkg::TRIM1_OFS: trim1_d = reg_wdata;
				atrb_pkg::TRIM2_OFS: trim2_d = reg_wdata;
				atrb_pkg::TRIM3_OFS: trim3_d = reg_wdata;
				// Test register writes are dropped to protect the die
				default: trim1_d = trim1_q;
			endcase
		end
		if (reg_rd) begin
			if (reg_addr == atrb_pkg::TRIM1_OFS) begin
				rdata_d = trim1_q & atrb_pkg::TRIM1_RD_MASK;
			end
		end
	end

	// Sense select is a pin from the analog side, so synchronise it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trim1_q   <= atrb_pkg::TRIM_RESET;
			trim2_q   <= atrb_pkg::TRIM_RESET;
			trim3_q   <= atrb_pkg::TRIM_RESET;
			reg_rdata <= 8'h00;
			sel_s1_q  <= 1'b0;
			sel_s2_q  <= 1'b0;
		end else if (clk_en) begin
			trim1_q   <= trim1_d;
			trim2_q   <= trim2_d;
			trim3_q   <= trim3_d;
			reg_rdata <= rdata_d;
			sel_s1_q  <= current_sense_select;
			sel_s2_q  <= sel_s1_q;
		end
	end

	// ==========================================
	// Trim decode
	logic [1:0]        dsel_d;
	logic [15:0]       fcyc_d;
	logic signed [4:0] ref_d, b12_d, b34_d, h23_d, h1_d;

	always_comb begin
		dsel_d = trim1_q[atrb_pkg::DLY_LSB +: 2];
		fcyc_d = dly_cyc(dsel_d);
		ref_d  = ref_pct(trim1_q[atrb_pkg::REF_LSB +: 4]);
		h1_d   = pct3(trim3_q[atrb_pkg::LO3_LSB +: 3]);
		h23_d  = pct3(trim3_q[atrb_pkg::MID3_LSB +: 3]);
		if (sel_s2_q) begin
			b12_d = pct3(trim2_q[atrb_pkg::LO3_LSB +: 3]);
			b34_d = pct3(trim2_q[atrb_pkg::MID3_LSB +: 3]);
		end else begin
			b12_d = pct2(trim2_q[atrb_pkg::HI2_LSB +: 2]);
			b34_d = pct2(trim3_q[atrb_pkg::HI2_LSB +: 2]);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			overcurrent_delay_sel     <= 2'h0;
			overcurrent_filter_cycles <= 16'(atrb_pkg::DLY0_CYC);
			ref_adjust_pct            <= 5'sd0;
			bridge12_adjust_pct       <= 5'sd0;
			bridge34_adjust_pct       <= 5'sd0;
			highside23_adjust_pct     <= 5'sd0;
			highside1_adjust_pct      <= 5'sd0;
		end else if (clk_en) begin
			overcurrent_delay_sel     <= dsel_d;
			overcurrent_filter_cycles <= fcyc_d;
			ref_adjust_pct            <= ref_d;
			bridge12_adjust_pct       <= b12_d;
			bridge34_adjust_pct       <= b34_d;
			highside23_adjust_pct     <= h23_d;
			highside1_adjust_pct      <= h1_d;
		end
	end
endmodule

// ---- atrb_top_tb_top.sv ----
// Self-checking bench for the trim register bank
`timescale 1ns/1ps
module atrb_top_tb_top;
	logic clk = 0, reset_n = 0, css = 0, wr, rd;
	logic [7:0] ad, wd, rdata;
	logic [1:0] sel;
	logic [15:0] filt;
	logic signed [4:0] rf, b12, b34, h23, h1;
	int n_errors = 0, n_compared = 0;
	logic signed [4:0] rt[9] = '{0, 2, 4, 8, 12, -2, -4, -8, -12};
	logic signed [4:0] gt[8] = '{0, -5, -10, -15, 0, 5, 10, 15};
	logic signed [4:0] g2[4] = '{0, -10, 5, 10};
	logic [15:0] ft[4] = '{16'h5CC6, 16'h3458, 16'h16DA, 16'h079E};
	initial forever #20 clk = ~clk;
	atrb_mcu mcu (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(ad),
		.reg_wdata(wd));
	atrb_top dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .reg_wr(wr),
		.reg_rd(rd), .reg_addr(ad), .reg_wdata(wd), .current_sense_select(css),
		.reg_rdata(rdata), .overcurrent_delay_sel(sel),
		.overcurrent_filter_cycles(filt), .ref_adjust_pct(rf),
		.bridge12_adjust_pct(b12), .bridge34_adjust_pct(b34),
		.highside23_adjust_pct(h23), .highside1_adjust_pct(h1));
	// =====
	// Tasks
	task automatic chk(input logic [15:0] s, e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic final_report;
		$display("Errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic t_boot;
		chk(filt, 16'h5CC6);
		chk(16'({rf, b12, b34}), 16'h0);
		chk(16'({h23, h1}), 16'h0);
		mcu.boot(8'hC3, 8'h73, 8'hAF);
		@(negedge clk);
		chk(16'(sel), 16'h3);
		chk(16'(rf), 16'(8));
		chk(16'(b12), -16'sd10);
		chk(16'(b34), 16'(5));
		chk(16'(h23), 16'(5));
		chk(16'(h1), 16'(15));
		css = 1;
		repeat (3) @(negedge clk);
		chk(16'(b34), 16'(10));
		chk(16'(b12), -16'sd15);
		css = 0;
		mcu.acc(1'b0, 8'h0F, 8'h00);
		chk(16'(rdata), 16'hC0);
		mcu.acc(1'b0, 8'h11, 8'h00);
		chk(16'(rdata), 16'h0);
	endtask
	task automatic t_codes;
		for (int i = 0; i < 9; i++) begin
			mcu.acc(1'b1, 8'h0F, {i[1:0], 2'b00, i[3:0]});
			@(negedge clk);
			chk(filt, ft[i % 4]);
			chk(16'(rf), 16'(rt[i]));
		end
		for (int i = 0; i < 8; i++) begin
			mcu.acc(1'b1, 8'h11, {i[1:0], i[2:0], i[2:0]});
			@(negedge clk);
			chk(16'(b34), 16'(g2[i % 4]));
			chk(16'(h23), 16'(gt[i]));
			chk(16'(h1), 16'(gt[i]));
		end
	endtask
	initial begin
		repeat (2) @(negedge clk);
		reset_n = 1;
		t_boot;
		t_codes;
		final_report;
	end
	initial begin
		#50000;
		n_errors++;
		final_report;
	end
endmodule
